// ===== logic/cgr_consts.svh
// constants of the clock generator reset-state block
// assumes an APB slave on a 12-bit byte address, 32-bit data
`ifndef CGR_CONSTS_SVH
`define CGR_CONSTS_SVH

// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
`define CGR_NUM_GEN        9
`define CGR_NUM_CHAN       46
`define CGR_LAST_CHAN      6'h2D

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define CGR_ADDR_OSC       12'h000
`define CGR_ADDR_CPU       12'h004
`define CGR_ADDR_OSC32K    12'h008
`define CGR_ADDR_STATUS    12'h00C
`define CGR_GEN_BASE       12'h020
`define CGR_GEN_LAST       12'h040
`define CGR_CHAN_BASE      12'h080
`define CGR_CHAN_LAST      12'h134

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define CGR_SRC_FAST_RC    5'h06
`define CGR_SRC_PLL        5'h07
`define CGR_SRC_FIRST_RSV  5'h08
`define CGR_GEN0_RESET     32'h0000_0106
`define CGR_GEN_RESET      32'h0000_0000
`define CGR_GEN_EN_BIT     8
`define CGR_GEN_WMASK      32'hFFFF_011F
`define CGR_FAST_DIV_RESET 8'h0C
`define CGR_NO_DIV         8'h01
`define CGR_CHAN_RESET     8'h00
`define CGR_CHAN_EN_BIT    6
`define CGR_CHAN_LOCK_BIT  7
`define CGR_CHAN_WMASK     8'hCF

`endif

// ===== logic/cgr_pkg.sv
// types of the clock generator reset-state block
// assumes nothing beyond the constants header
package cgr_pkg;
	typedef logic [31:0] cgr_word_t;
	typedef logic [7:0]  cgr_chan_t;
	typedef logic [3:0]  cgr_gen_idx_t;
endpackage : cgr_pkg

// ===== logic/cgr_chan_bank.sv
// per-peripheral clock channel control store
// assumes writes and reset requests come from logic on pclk
`include "cgr_consts.svh"

module cgr_chan_bank (
	input  wire logic                          pclk,
	input  wire logic                          presetn,
	input  wire logic                          user_reset,
	input  wire logic                          wr_en,
	input  wire logic [5:0]                    wr_idx,
	input  wire cgr_pkg::cgr_chan_t            wr_data,
	input  wire logic [5:0]                    rd_idx,
	output cgr_pkg::cgr_chan_t                 rd_data,
	output logic [`CGR_NUM_CHAN-1:0]           chan_en,
	output logic [`CGR_NUM_GEN-1:0]            gen_locked
);
	cgr_pkg::cgr_chan_t chan [`CGR_NUM_CHAN];

	// ----------------------------------------------------------------
	// channel registers
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < `CGR_NUM_CHAN; i++) begin
				chan[i] <= `CGR_CHAN_RESET;
			end
		end else if (user_reset) begin
			for (int i = 0; i < `CGR_NUM_CHAN; i++) begin
				if (!chan[i][`CGR_CHAN_LOCK_BIT]) begin
					chan[i] <= `CGR_CHAN_RESET;
				end
			end
		end else if (wr_en && !chan[wr_idx][`CGR_CHAN_LOCK_BIT]) begin
			// a locked channel ignores writes until power reset
			chan[wr_idx] <= wr_data & `CGR_CHAN_WMASK;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_data <= `CGR_CHAN_RESET;
		end else begin
			rd_data <= chan[rd_idx];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chan_en <= '0;
		end else begin
			for (int i = 0; i < `CGR_NUM_CHAN; i++) begin
				chan_en[i] <= chan[i][`CGR_CHAN_EN_BIT];
			end
		end
	end

	// ----------------------------------------------------------------
	// generators that feed a locked channel
	// ----------------------------------------------------------------
	always_comb begin
		gen_locked = '0;
		for (int i = 0; i < `CGR_NUM_CHAN; i++) begin
			for (int g = 0; g < `CGR_NUM_GEN; g++) begin
				if (chan[i][`CGR_CHAN_LOCK_BIT] && chan[i][3:0] == 4'(g)) begin
					gen_locked[g] = 1'b1;
				end
			end
		end
	end
endmodule : cgr_chan_bank

// ===== logic/cgr_clock_ctrl.sv
// clock controller reset-state logic with APB register access
// assumes presetn is the power reset and user_reset a pclk-synchronous level
`include "cgr_consts.svh"

module cgr_clock_ctrl (
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	input  wire logic                        user_reset,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [11:0]                 paddr,
	input  wire logic [31:0]                 pwdata,
	output logic [31:0]                      prdata,
	output logic                             pready,
	output logic                             pslverr,
	output logic                             fast_rc_oscillator_en,
	output logic [7:0]                       fast_rc_div,
	output logic [4:0]                       main_clock_path_src,
	output logic [7:0]                       cpu_div,
	output logic [7:0]                       bus_div,
	output logic                             osc32k_en,
	output logic [`CGR_NUM_GEN-1:0]          gen_en,
	output logic [`CGR_NUM_CHAN-1:0]         chan_en
);
	cgr_pkg::cgr_word_t  generator_control_reg [`CGR_NUM_GEN];
	logic [`CGR_NUM_GEN-1:0] gen_locked;
	cgr_pkg::cgr_chan_t  chan_rd;
	cgr_pkg::cgr_word_t  rd_hold;
	logic                rd_from_bank;
	logic                setup;
	logic                access;
	logic                hit_gen;
	logic                hit_chan;
	logic                hit_fixed;
	logic [5:0]          chan_idx;
	cgr_pkg::cgr_gen_idx_t gen_idx;
	cgr_pkg::cgr_word_t  next_gen_word;
	cgr_pkg::cgr_word_t  next_rd_hold;
	logic                wr_ok;
	logic                wr_osc;
	logic                wr_cpu;
	logic                wr_osc32k;
	logic                wr_gen;
	logic                wr_chan;

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	function automatic logic in_range(input logic [11:0] a, input logic [11:0] lo,
			input logic [11:0] hi);
		in_range = a >= lo && a <= hi && a[1:0] == 2'b00;
	endfunction : in_range

	function automatic logic [5:0] word_idx(input logic [11:0] a, input logic [11:0] base);
		logic [11:0] d;
		d = a - base;
		word_idx = d[7:2];
	endfunction : word_idx

	function automatic logic src_legal(input logic [4:0] s);
		src_legal = s < `CGR_SRC_FIRST_RSV;
	endfunction : src_legal

	// reserved source codes leave the old source in place
	function automatic cgr_pkg::cgr_word_t gen_merge(input cgr_pkg::cgr_word_t old,
			input cgr_pkg::cgr_word_t wr);
		cgr_pkg::cgr_word_t m;
		m = wr & `CGR_GEN_WMASK;
		if (!src_legal(wr[4:0])) begin
			m[4:0] = old[4:0];
		end
		gen_merge = m;
	endfunction : gen_merge

	assign setup     = psel && !penable;
	assign access    = psel && penable;
	assign hit_gen   = in_range(paddr, `CGR_GEN_BASE, `CGR_GEN_LAST);
	assign hit_chan  = in_range(paddr, `CGR_CHAN_BASE, `CGR_CHAN_LAST);
	assign hit_fixed = in_range(paddr, `CGR_ADDR_OSC, `CGR_ADDR_STATUS);
	assign chan_idx  = word_idx(paddr, `CGR_CHAN_BASE);
	assign gen_idx   = 4'(word_idx(paddr, `CGR_GEN_BASE));
	assign pready    = 1'b1;
	assign pslverr   = access && !(hit_gen || hit_chan || hit_fixed);
	assign prdata    = rd_from_bank ? {24'h000000, chan_rd} : rd_hold;
	assign main_clock_path_src = generator_control_reg[0][4:0];

	// ----------------------------------------------------------------
	// write strobes, user reset outranks a write
	// ----------------------------------------------------------------
	assign wr_ok     = access && pwrite && !user_reset;
	assign wr_osc    = wr_ok && paddr == `CGR_ADDR_OSC;
	assign wr_cpu    = wr_ok && paddr == `CGR_ADDR_CPU;
	assign wr_osc32k = wr_ok && paddr == `CGR_ADDR_OSC32K;
	assign wr_gen    = wr_ok && hit_gen;
	assign wr_chan   = wr_ok && hit_chan;

	// ----------------------------------------------------------------
	// fast RC oscillator and CPU/bus path reset by any reset, 32 kHz source by power reset only
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fast_rc_oscillator_en <= 1'b1;
			fast_rc_div           <= `CGR_FAST_DIV_RESET;
		end else if (user_reset) begin
			fast_rc_oscillator_en <= 1'b1;
			fast_rc_div           <= `CGR_FAST_DIV_RESET;
		end else if (wr_osc) begin
			fast_rc_oscillator_en <= pwdata[0];
			fast_rc_div           <= pwdata[15:8];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cpu_div <= `CGR_NO_DIV;
			bus_div <= `CGR_NO_DIV;
		end else if (user_reset) begin
			cpu_div <= `CGR_NO_DIV;
			bus_div <= `CGR_NO_DIV;
		end else if (wr_cpu) begin
			cpu_div <= pwdata[7:0];
			bus_div <= pwdata[15:8];
		end
	end

	// 32 kHz source ignores user reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			osc32k_en <= 1'b1;
		end else if (wr_osc32k) begin
			osc32k_en <= pwdata[0];
		end
	end

	// ----------------------------------------------------------------
	// generator control registers
	// ----------------------------------------------------------------
	always_comb begin
		next_gen_word = `CGR_GEN_RESET;
		if (hit_gen) begin
			next_gen_word = gen_merge(generator_control_reg[gen_idx], pwdata);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			generator_control_reg[0] <= `CGR_GEN0_RESET;
			for (int g = 1; g < `CGR_NUM_GEN; g++) begin
				generator_control_reg[g] <= `CGR_GEN_RESET;
			end
		end else if (user_reset) begin
			generator_control_reg[0] <= `CGR_GEN0_RESET;
			for (int g = 1; g < `CGR_NUM_GEN; g++) begin
				if (!gen_locked[g]) begin
					generator_control_reg[g] <= `CGR_GEN_RESET;
				end
			end
		end else if (wr_gen) begin
			generator_control_reg[gen_idx] <= next_gen_word;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gen_en <= '0;
		end else begin
			for (int g = 0; g < `CGR_NUM_GEN; g++) begin
				gen_en[g] <= generator_control_reg[g][`CGR_GEN_EN_BIT];
			end
		end
	end

	// ----------------------------------------------------------------
	// channel store
	// ----------------------------------------------------------------
	cgr_chan_bank u_bank (
		.pclk       (pclk),
		.presetn    (presetn),
		.user_reset (user_reset),
		.wr_en      (wr_chan),
		.wr_idx     (chan_idx),
		.wr_data    (pwdata[7:0]),
		.rd_idx     (chan_idx),
		.rd_data    (chan_rd),
		.chan_en    (chan_en),
		.gen_locked (gen_locked)
	);

	// ----------------------------------------------------------------
	// read path, captured in the setup cycle
	// ----------------------------------------------------------------
	always_comb begin
		next_rd_hold = '0;
		if (hit_gen) begin
			next_rd_hold = generator_control_reg[gen_idx];
		end else begin
			case (paddr)
				`CGR_ADDR_OSC: begin
					next_rd_hold = {16'h0000, fast_rc_div, 7'h00, fast_rc_oscillator_en};
				end
				`CGR_ADDR_CPU: begin
					next_rd_hold = {16'h0000, bus_div, cpu_div};
				end
				`CGR_ADDR_OSC32K: begin
					next_rd_hold = {31'h00000000, osc32k_en};
				end
				`CGR_ADDR_STATUS: begin
					next_rd_hold = {16'h0000, 7'h00, gen_locked};
				end
				default: begin
					next_rd_hold = '0;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_hold      <= '0;
			rd_from_bank <= 1'b0;
		end else if (setup) begin
			rd_from_bank <= hit_chan;
			rd_hold      <= next_rd_hold;
		end
	end
endmodule : cgr_clock_ctrl

// ===== testbench/cgr_rst_src_model.sv
// model of the system reset controller driving the user reset level
// assumes requests arrive synchronous to pclk
module cgr_rst_src_model (
	input  wire logic pclk,
	input  wire logic req,
	output logic      user_reset
);
	timeunit 1ns;
	timeprecision 1ps;
	always_ff @(posedge pclk) begin
		user_reset <= req;
	end
endmodule : cgr_rst_src_model

// ===== testbench/cgr_checker.sv
// assertions on the reset-state outputs, source selection and error response of the clock controller
// assumes one pclk domain, bound to cgr_clock_ctrl
`include "cgr_consts.svh"
module cgr_checker (
	input wire logic                      pclk,
	input wire logic                      presetn,
	input wire logic                      user_reset,
	input wire logic                      psel,
	input wire logic                      penable,
	input wire logic                      pwrite,
	input wire logic [11:0]               paddr,
	input wire logic [31:0]               pwdata,
	input wire logic                      pslverr,
	input wire logic                      fast_rc_oscillator_en,
	input wire logic [7:0]                fast_rc_div,
	input wire logic [4:0]                main_clock_path_src,
	input wire logic [7:0]                cpu_div,
	input wire logic [7:0]                bus_div,
	input wire logic                      osc32k_en,
	input wire logic [`CGR_NUM_GEN-1:0]   gen_en,
	input wire logic [`CGR_NUM_CHAN-1:0]  chan_en
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	logic g0w;
	assign g0w = psel && penable && pwrite && paddr == 12'h020 && !user_reset;
	property p_fast_rc;
		user_reset |=> fast_rc_oscillator_en && fast_rc_div == 8'h0C;
	endproperty
	a_fast_rc: assert property (p_fast_rc) else $error("fast RC not restored");
	property p_div;
		user_reset |=> main_clock_path_src == 5'h06 && cpu_div == 8'h01 && bus_div == 8'h01;
	endproperty
	a_div: assert property (p_div) else $error("main path not restored");
	property p_osc32k;
		user_reset |=> osc32k_en == $past(osc32k_en);
	endproperty
	a_osc32k: assert property (p_osc32k) else $error("32k source touched");
	property p_por;
		$rose(presetn) |-> gen_en == '0 && chan_en == '0 ##1 gen_en == 9'h001;
	endproperty
	a_por: assert property (p_por) else $error("power-up enables wrong");
	property p_src_rsv;
		g0w && pwdata[4:0] >= 5'h08 |=> $stable(main_clock_path_src);
	endproperty
	a_src_rsv: assert property (p_src_rsv) else $error("reserved source taken");
	property p_src_ok;
		g0w && pwdata[4:1] == 4'h3 |=> main_clock_path_src == $past(pwdata[4:0]);
	endproperty
	a_src_ok: assert property (p_src_ok) else $error("source not taken");
	property p_gen0;
		user_reset |-> ##2 gen_en[0];
	endproperty
	a_gen0: assert property (p_gen0) else $error("generator 0 off");
	property p_unmapped;
		psel && penable && paddr > 12'h134 |-> pslverr;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("no error past last channel");
endmodule : cgr_checker
bind cgr_clock_ctrl cgr_checker u_chk (
	.pclk                  (pclk),
	.presetn               (presetn),
	.user_reset            (user_reset),
	.psel                  (psel),
	.penable               (penable),
	.pwrite                (pwrite),
	.paddr                 (paddr),
	.pwdata                (pwdata),
	.pslverr               (pslverr),
	.fast_rc_oscillator_en (fast_rc_oscillator_en),
	.fast_rc_div           (fast_rc_div),
	.main_clock_path_src   (main_clock_path_src),
	.cpu_div               (cpu_div),
	.bus_div               (bus_div),
	.osc32k_en             (osc32k_en),
	.gen_en                (gen_en),
	.chan_en               (chan_en)
);

// ===== testbench/clock_generator_reset_state_bench.sv
// self-checking bench of the clock controller reset states
// assumes cgr_clock_ctrl with zero-wait APB, user reset from a model
module clock_generator_reset_state_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 0, presetn = 0, req = 0, user_reset;
	logic psel = 0, penable = 0, pwrite = 0, pready, pslverr, fast_rc_oscillator_en, osc32k_en;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rnd;
	logic [7:0] fast_rc_div, cpu_div, bus_div;
	logic [4:0] main_clock_path_src;
	logic [8:0] gen_en;
	logic [45:0] chan_en;
	logic [31:0] q[$];
	int err_total = 0, n_compared = 0;
	always #2.5 pclk = ~pclk;
	cgr_rst_src_model u_rst (.pclk(pclk), .req(req), .user_reset(user_reset));
	cgr_clock_ctrl u_dut (.pclk(pclk), .presetn(presetn), .user_reset(user_reset), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .fast_rc_oscillator_en(fast_rc_oscillator_en),
		.fast_rc_div(fast_rc_div), .main_clock_path_src(main_clock_path_src), .cpu_div(cpu_div),
		.bus_div(bus_div), .osc32k_en(osc32k_en), .gen_en(gen_en), .chan_en(chan_en));
	function logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task chk(input logic [63:0] got, input logic [63:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task tally_and_finish;
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : tally_and_finish
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] e);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		if (!w) q.push_back(e);
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		@(posedge pclk);
		while (!pready && n < 50) begin
			n++;
			@(posedge pclk);
		end
		if (!pready) begin
			err_total++;
			tally_and_finish;
		end else begin
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask : apb
	task power_reset;
		presetn <= 0;
		repeat (4) @(posedge pclk);
		presetn <= 1;
	endtask : power_reset
	// ----------------------------------------------------------------
	// read monitor
	// ----------------------------------------------------------------
	always @(posedge pclk) begin
		if (psel && penable && pready && !pwrite && q.size() > 0) chk(prdata, q.pop_front());
	end
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		rnd = lfsr(32'h9567);
		power_reset;
		#1;
		chk({fast_rc_oscillator_en, fast_rc_div}, 9'h10C);
		chk({main_clock_path_src, cpu_div, bus_div}, {5'h06, 16'h0101});
		@(posedge pclk);
		#1;
		chk({chan_en, gen_en}, 55'h1);
		apb(0, 12'h020, 0, 32'h106);
		apb(0, 12'h024, 0, 0);
		apb(0, 12'h080, 0, 0);
		apb(1, 12'h094, 32'hC3, 0);
		apb(1, 12'h098, 32'h44, 0);
		apb(1, 12'h02C, 32'h107, 0);
		apb(1, 12'h030, 32'h106, 0);
		apb(1, 12'h028, {rnd[31:16], 16'h0107}, 0);
		apb(0, 12'h028, 0, {rnd[31:16], 16'h0107});
		apb(1, 12'h000, 0, 0);
		apb(1, 12'h008, 0, 0);
		apb(1, 12'h004, 32'h0202, 0);
		apb(1, 12'h020, 32'h107, 0);
		apb(1, 12'h020, 32'h11F, 0);
		apb(0, 12'h020, 0, 32'h107);
		apb(1, 12'h134, 32'h41, 0);
		apb(0, 12'h134, 0, 32'h41);
		apb(0, 12'h138, 0, 0);
		#1;
		chk({fast_rc_oscillator_en, fast_rc_div, cpu_div, bus_div}, 25'h0202);
		chk({osc32k_en, main_clock_path_src, gen_en}, {1'b0, 5'h07, 9'h01D});
		chk(chan_en, 46'h2000_0000_0060);
		@(posedge pclk) req <= 1'b1;
		@(posedge pclk) req <= 1'b0;
		repeat (3) @(posedge pclk);
		apb(0, 12'h000, 0, 32'h0C01);
		apb(0, 12'h004, 0, 32'h0101);
		apb(0, 12'h008, 0, 0);
		apb(0, 12'h020, 0, 32'h106);
		apb(0, 12'h028, 0, 0);
		apb(0, 12'h02C, 0, 32'h107);
		apb(0, 12'h030, 0, 0);
		apb(0, 12'h094, 0, 32'hC3);
		apb(0, 12'h098, 0, 0);
		apb(0, 12'h134, 0, 0);
		#1;
		chk({osc32k_en, main_clock_path_src, gen_en}, {1'b0, 5'h06, 9'h009});
		chk(chan_en, 46'h20);
		@(posedge pclk);
		power_reset;
		apb(0, 12'h094, 0, 0);
		apb(0, 12'h02C, 0, 0);
		apb(0, 12'h008, 0, 32'h1);
		repeat (2) @(posedge pclk);
		#1;
		chk({osc32k_en, chan_en, gen_en}, {1'b1, 46'h0, 9'h001});
		tally_and_finish;
	end
endmodule : clock_generator_reset_state_bench
